//--- inc/sadc_pkg.sv
/*
  Constants shared by the serial converter frame and power-mode control:
  frame edge counts, word layout, synchroniser depth and clock figures.
  Assumes a host that frames each conversion with an active-low select.
*/
package sadc_pkg;

  // Word layout on the serial output.
  localparam int CODE_BITS = 12;
  localparam int LEAD_ZEROS = 3;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h1F;

  // Serial clock falling-edge counts that decide the mode and the data bits.
  localparam logic [CNT_BITS-1:0] FALL_DOWN_MIN = 5'h02;
  localparam logic [CNT_BITS-1:0] FALL_KEEP_MIN = 5'h0A;
  localparam logic [CNT_BITS-1:0] FALL_WORD_END = 5'h10;
  localparam logic [CNT_BITS-1:0] FALL_FIRST_BIT = 5'h03;
  localparam logic [CNT_BITS-1:0] FALL_LAST_BIT = 5'h0E;
  // Falls seen before the rising edge that returns to tracking (12th).
  localparam logic [CNT_BITS-1:0] FALL_BEFORE_TRACK = 5'h0C;

  // Synchroniser depth and the width of the crossing bundle.
  localparam int SYNC_STAGES = 2;
  localparam int XING_BITS = 5;

  // System clock and the least track interval of the host.
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int TRACK_INTERVAL_MIN_NS = 350;
  localparam int TRACK_INTERVAL_MIN_CYC =
    (TRACK_INTERVAL_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Power modes of the analog core.
  typedef enum logic [1:0] {
    MODE_DOWN,
    MODE_WAKE,
    MODE_UP
  } sadc_mode_t;

endpackage

//--- hdl/sadc_sync.sv
/*
  Multi-bit level synchroniser, one independent chain per bit.
  Assumes each bit is a slow level whose bits need not arrive together.
*/
`timescale 1ns/100ps
module sadc_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  // Clock, reset and freeze.
  input wire logic clock,
  input wire logic nrst,
  input wire logic clockEn,
  // Levels in and out.
  input wire logic [WIDTH-1:0] levelIn,
  output logic [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] chain_r [STAGES];

  initial begin
    if (STAGES < 2 || WIDTH < 1) begin
      $error("sadc_sync needs at least two stages and one bit");
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_r[i] <= '0;
      end
    end else if (clockEn) begin
      chain_r[0] <= levelIn;
      for (int i = 1; i < STAGES; i++) begin
        chain_r[i] <= chain_r[i-1];
      end
    end
  end

  assign levelOut = chain_r[STAGES-1];

endmodule

//--- hdl/sadc_frame_ctrl.sv
/*
  Frame and power-mode control of a serial 12-bit converter.
  The link side runs on the serial clock and is cleared while select is
  high; the mode machine runs on the system clock and sees the link only
  through synchronised levels. Assumes the analog core hands over its
  code on convCode and holds it steady for the frame.
*/
// Operation
// - Result is a 12-bit unsigned straight binary code.
// - Select fall starts a conversion and enters normal mode.
// - Rise between falls two and ten aborts, floats output, shuts down.
// - Rise before fall two leaves the power mode unchanged.
// - Rise between falls ten and sixteen aborts, floats, stays normal.
// - Output floats after sixteen falls; host waits the quiet gap.
// - Shutdown holds until the next select fall.
// - Select fall in shutdown powers up; that result is invalid.
// - Power-up frame ended before fall ten returns to shutdown.
// - Power-up frame past fall ten is fully powered after sixteen.
// - Select fall drives the output and holds the sample.
// - Three zeros then twelve bits, MSB first, on clock falls.
// - Tracking resumes on the 13th rising clock edge; this block resumes on the 12th.
`timescale 1ns/100ps
module sadc_frame_ctrl
  import sadc_pkg::*;
#(
  parameter int WIDTH = CODE_BITS
) (
  // System clock, reset and freeze.
  input wire logic clock,
  input wire logic nrst,
  input wire logic clockEn,
  // Serial link from the host.
  input wire logic sclk,
  input wire logic csN,
  output logic serialResultOut,
  output logic serialResultOe,
  // Analog core.
  input wire logic [WIDTH-1:0] convCode,
  output logic sampleHold,
  output logic convStart,
  output logic analogPowerOn,
  output logic resultValid
);

  initial begin
    if (WIDTH != CODE_BITS) begin
      $error("sadc_frame_ctrl serves only a 12-bit code");
    end
  end

  // Code captured at the select fall; it stays put while the link shifts it.
  logic [WIDTH-1:0] heldCode_r;
  // Link domain: cleared whenever select is high or at reset.
  logic linkClr;
  logic [CNT_BITS-1:0] fallCnt_r;
  logic [CNT_BITS-1:0] fallCnt_nxt;
  logic dataBit_r;
  logic dataBit_nxt;
  logic seen2_r;
  logic seen10_r;
  logic seen16_r;
  logic track_r;
  logic inBits;
  logic [CNT_BITS-1:0] bitIdx;

  assign linkClr = ~nrst | csN;
  assign fallCnt_nxt = (fallCnt_r == CNT_MAX) ? fallCnt_r
                                               : fallCnt_r + CNT_ONE;
  assign inBits = (fallCnt_nxt >= FALL_FIRST_BIT) &&
                  (fallCnt_nxt <= FALL_LAST_BIT);
  assign bitIdx = FALL_LAST_BIT - fallCnt_nxt;
  assign dataBit_nxt = inBits & heldCode_r[bitIdx[3:0]];

  // Falls are counted from the select fall, saturating.
  always_ff @(negedge sclk or posedge linkClr) begin
    if (linkClr) begin
      fallCnt_r <= CNT_ZERO;
      dataBit_r <= 1'b0;
      seen2_r <= 1'b0;
      seen10_r <= 1'b0;
      seen16_r <= 1'b0;
    end else begin
      fallCnt_r <= fallCnt_nxt;
      dataBit_r <= dataBit_nxt;
      seen2_r <= seen2_r | (fallCnt_nxt >= FALL_DOWN_MIN);
      seen10_r <= seen10_r | (fallCnt_nxt >= FALL_KEEP_MIN);
      seen16_r <= seen16_r | (fallCnt_nxt >= FALL_WORD_END);
    end
  end

  // The 12th rising edge returns the core to tracking.
  always_ff @(posedge sclk or posedge linkClr) begin
    if (linkClr) begin
      track_r <= 1'b0;
    end else if (fallCnt_r >= FALL_BEFORE_TRACK) begin
      track_r <= 1'b1;
    end
  end

  assign serialResultOut = dataBit_r;

  // Crossing into the system domain.
  logic [XING_BITS-1:0] xingIn;
  logic [XING_BITS-1:0] xingOut;
  logic csLowS;
  logic seen2S;
  logic seen10S;
  logic seen16S;
  logic trackS;

  assign xingIn = {~csN, seen2_r, seen10_r, seen16_r, track_r};

  sadc_sync #(
    .WIDTH(XING_BITS),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .clockEn(clockEn),
    .levelIn(xingIn),
    .levelOut(xingOut)
  );

  assign {csLowS, seen2S, seen10S, seen16S, trackS} = xingOut;

  // System domain. Select high clears the edge flags in the link at once,
  // so the flags are held one more stage and read from there on a rise.
  logic csLow_r;
  logic seen2Q_r;
  logic seen10Q_r;
  sadc_mode_t mode_r;
  sadc_mode_t mode_nxt;
  logic csFall;
  logic csRise;
  logic oe_r;
  logic hold_r;
  logic start_r;
  logic power_r;
  logic valid_r;

  assign csFall = csLowS & ~csLow_r;
  assign csRise = ~csLowS & csLow_r;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_DOWN: begin
        if (csFall) begin
          mode_nxt = MODE_WAKE;
        end
      end
      MODE_WAKE: begin
        if (csRise && !seen10Q_r) begin
          mode_nxt = MODE_DOWN;
        end else if (csRise || seen16S) begin
          mode_nxt = MODE_UP;
        end
      end
      MODE_UP: begin
        if (csRise && seen2Q_r && !seen10Q_r) begin
          mode_nxt = MODE_DOWN;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      csLow_r <= 1'b0;
      heldCode_r <= '0;
      seen2Q_r <= 1'b0;
      seen10Q_r <= 1'b0;
      mode_r <= MODE_DOWN;
      oe_r <= 1'b0;
      hold_r <= 1'b0;
      start_r <= 1'b0;
      power_r <= 1'b0;
      valid_r <= 1'b0;
    end else if (clockEn) begin
      csLow_r <= csLowS;
      seen2Q_r <= seen2S;
      seen10Q_r <= seen10S;
      mode_r <= mode_nxt;
      // The output floats on select rise or after sixteen falls.
      oe_r <= csLowS & ~seen16S;
      hold_r <= csLowS & ~trackS;
      start_r <= csFall;
      power_r <= (mode_nxt != MODE_DOWN);
      if (csFall) begin
        heldCode_r <= convCode;
        valid_r <= (mode_r == MODE_UP);
      end
    end
  end

  assign serialResultOe = oe_r;
  assign sampleHold = hold_r;
  assign convStart = start_r;
  assign analogPowerOn = power_r;
  assign resultValid = valid_r;

endmodule

//--- tb/sadc_frame_ctrl_chk.sv
/*
  Port assertions of the converter frame and power-mode control.
  Assumes the host holds select at least three clocks at each level.
*/
`timescale 1ns/100ps
module sadc_frame_ctrl_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Link and core.
  input wire logic csN,
  input wire logic serialResultOut,
  input wire logic serialResultOe,
  input wire logic sampleHold,
  input wire logic convStart,
  input wire logic analogPowerOn,
  input wire logic resultValid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  property p_start;
    $fell(csN) |-> ##[2:5] convStart;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_pulse;
    convStart |=> !convStart;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  property p_drive;
    convStart |-> serialResultOe && sampleHold;
  endproperty
  a_drive: assert property (p_drive) else $error("no drive");
  property p_float;
    csN [*6] |-> !serialResultOe;
  endproperty
  a_float: assert property (p_float) else $error("not floated");
  property p_zero;
    csN && $past(csN) |-> !serialResultOut;
  endproperty
  a_zero: assert property (p_zero) else $error("data idle");
  property p_track;
    csN [*6] |-> !sampleHold;
  endproperty
  a_track: assert property (p_track) else $error("still held");
  property p_wake;
    $rose(analogPowerOn) |-> !$past(csN, 2);
  endproperty
  a_wake: assert property (p_wake) else $error("stray wake");
  property p_down;
    $fell(analogPowerOn) |-> csN;
  endproperty
  a_down: assert property (p_down) else $error("stray down");
  property p_invalid;
    $rose(analogPowerOn) |-> ##[0:2] !resultValid;
  endproperty
  a_invalid: assert property (p_invalid) else $error("dummy valid");
  c_start: cover property (convStart);
  c_down: cover property ($fell(analogPowerOn));
  c_valid: cover property ($rose(resultValid));
endmodule
bind sadc_frame_ctrl sadc_frame_ctrl_chk chkU (.clock(clock), .nrst(nrst),
  .csN(csN), .serialResultOut(serialResultOut),
  .serialResultOe(serialResultOe), .sampleHold(sampleHold),
  .convStart(convStart), .analogPowerOn(analogPowerOn),
  .resultValid(resultValid));

//--- tb/sadc_host_model.sv
/*
  Host model that frames conversions with select and a gated clock.
  Assumes the converter output is undriven while its enable is low.
*/
`timescale 1ns/100ps
module sadc_host_model (
  // Link to the converter.
  output logic csN,
  output logic sclk,
  input wire logic serialResultOut,
  input wire logic serialResultOe
);
  logic lastBit = 1'b0;
  // A released line shows the inverse of the last bit seen.
  wire line = serialResultOe ? serialResultOut : ~lastBit;
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
  end
  task automatic run(input int n, output logic [15:0] w);
    w = 16'h0000;
    #7 csN = 1'b0;
    #100;
    for (int k = 1; k <= n; k++) begin
      #40;
      // Each bit is taken just before the fall that replaces it.
      w = {w[14:0], line};
      lastBit = line;
      sclk = 1'b0;
      #40 sclk = 1'b1;
      if (k == 13) #360;
    end
    #40 csN = 1'b1;
    #400;
  endtask
endmodule

//--- tb/test_serial_adc_frame_power_control.sv
/*
  Self-checking bench of the frame and power-mode control.
  Assumes the host model and bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module test_serial_adc_frame_power_control
  import sadc_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clockEn = 1'b1;
  logic [CODE_BITS-1:0] convCode = 12'h000;
  logic sclk, csN, serialResultOut, serialResultOe;
  logic sampleHold, convStart, analogPowerOn, resultValid;
  int err_count = 0;
  int n_compared = 0;
  int falls [11] = '{16, 16, 12, 1, 5, 1, 5, 16, 16, 16, 16};
  logic [10:0] pwr = 11'h78F;
  logic [10:0] vld = 11'h71E;
  logic [15:0] word;
  sadc_frame_ctrl dut_u (.clock(clock), .nrst(nrst), .clockEn(clockEn),
    .sclk(sclk), .csN(csN), .serialResultOut(serialResultOut),
    .serialResultOe(serialResultOe), .convCode(convCode),
    .sampleHold(sampleHold), .convStart(convStart),
    .analogPowerOn(analogPowerOn), .resultValid(resultValid));
  sadc_host_model hostU (.csN(csN), .sclk(sclk),
    .serialResultOut(serialResultOut), .serialResultOe(serialResultOe));
  initial begin
    forever #10 clock = ~clock;
  end
  function automatic logic [15:0] frame_word(input logic [11:0] c);
    return {3'h0, c, 1'h0};
  endfunction
  task chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'ha7cb));
    repeat (12) @(posedge clock);
    @(negedge clock) nrst = 1'b1;
    repeat (4) @(posedge clock);
    // Frame table: dummy, valid, aborts, shutdown, two wake aborts, wake, valid,
    // then two valid frames with random codes.
    for (int i = 0; i < 11; i++) begin
      @(negedge clock);
      convCode = (i == 1) ? 12'hfff : (i == 8) ? 12'h000 : 12'($urandom());
      hostU.run(falls[i], word);
      chk_bit(serialResultOe, 1'b0);
      chk_bit(analogPowerOn, pwr[i]);
      chk_bit(resultValid, vld[i]);
      if (falls[i] == 16 && vld[i]) chk_word(word, frame_word(convCode));
    end
    give_verdict();
  end
endmodule
